// ==== mel_log_bank.sv ====
/*
 * Memory error log bank: first-error capture registers behind a classic Wishbone slave.
 * Assumes error reports are one-cycle pulses synchronous to clk_i and a Wishbone master
 * that holds each request until it sees ack.
 */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "mel_regs.svh"

module mel_log_bank
   import mel_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [11:0]  wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   // Error reports from the memory channels
   input  wire mel_mem_evt_t fatal_mem_i,
   input  wire mel_mem_evt_t nonfatal_mem_i,
   input  wire mel_cfg_evt_t cfg_err_i,
   input  wire mel_crc_evt_t crc_err_i,
   input  wire mel_ecc_evt_t ecc_err_i,
   // Which logs hold a capture
   output logic [4:0]        log_filled_o
);

   mel_state_t            s_q;
   mel_state_t            s_d;
   logic [9:0]            idx;
   logic                  req;
   logic [`MEL_LOC_W-1:0] loc_in;
   logic [4:0]            arm;

   assign idx = wb_adr_i[11:2];
   assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;

   // Fold symbol-pair flags into locator order: check 0 sits between the two data halves, check 1 on top.
   assign loc_in = {ecc_err_i.check_pair[1], ecc_err_i.data_pair[15:8],
                    ecc_err_i.check_pair[0], ecc_err_i.data_pair[7:0]};

   // A class captures only while enabled and still empty, so later errors never overwrite.
   genvar g;
   generate
      for (g = 0; g < `MEL_LOG_CLASSES; g++) begin : g_arm
         assign arm[g] = s_q.enable[g] & ~s_q.filled[g];
      end
   endgenerate

   always_comb begin
      s_d      = s_q;
      s_d.ack  = req;
      s_d.rdata = 32'h0;

      if (fatal_mem_i.valid && arm[MEL_CLS_FATAL_MEM]) begin
         s_d.fatal_req  = {1'b0, fatal_mem_i.bank, fatal_mem_i.dir,
                           fatal_mem_i.rank, fatal_mem_i.buf_id};
         s_d.fatal_addr = {4'h0, fatal_mem_i.col, 1'b0, fatal_mem_i.row};
         s_d.filled[MEL_CLS_FATAL_MEM] = 1'b1;
      end
      if (nonfatal_mem_i.valid && arm[MEL_CLS_NONFATAL_MEM]) begin
         s_d.nonfatal_req = {1'b0, nonfatal_mem_i.bank, nonfatal_mem_i.dir,
                             nonfatal_mem_i.rank, nonfatal_mem_i.buf_id};
         s_d.filled[MEL_CLS_NONFATAL_MEM] = 1'b1;
      end
      if (cfg_err_i.valid && arm[MEL_CLS_CFG]) begin
         s_d.cfg_log = {4'h0, cfg_err_i.byte_lane_enables, cfg_err_i.reg_offset, 4'h0,
                        cfg_err_i.dir, cfg_err_i.func, cfg_err_i.buf_id};
         s_d.filled[MEL_CLS_CFG] = 1'b1;
      end
      if (crc_err_i.valid && arm[MEL_CLS_CRC]) begin
         s_d.crc_frame = crc_err_i.frame;
         s_d.filled[MEL_CLS_CRC] = 1'b1;
      end
      if (ecc_err_i.valid && arm[MEL_CLS_ECC]) begin
         s_d.ecc_loc = loc_in;
         s_d.filled[MEL_CLS_ECC] = 1'b1;
      end

      // Only the control word is writable; the logs ignore every write.
      if (req && wb_we_i && idx == `MEL_IDX_CTRL && wb_sel_i[0]) begin
         s_d.enable = wb_dat_i[`MEL_LOG_CLASSES-1:0];
      end

      if (req && !wb_we_i) begin
         unique case (idx)
            `MEL_IDX_ECC_LOC:      s_d.rdata = {14'h0, s_q.ecc_loc};
            `MEL_IDX_FATAL_REQ:    s_d.rdata = {16'h0, s_q.fatal_req};
            `MEL_IDX_FATAL_ADDR:   s_d.rdata = s_q.fatal_addr;
            `MEL_IDX_CFG_ERR:      s_d.rdata = s_q.cfg_log;
            `MEL_IDX_CRC_A:        s_d.rdata = s_q.crc_frame[31:0];
            `MEL_IDX_CRC_B:        s_d.rdata = s_q.crc_frame[63:32];
            `MEL_IDX_CRC_C:        s_d.rdata = s_q.crc_frame[95:64];
            `MEL_IDX_CRC_D:        s_d.rdata = s_q.crc_frame[127:96];
            `MEL_IDX_CRC_E:        s_d.rdata = {4'h0, s_q.crc_frame[155:128]};
            `MEL_IDX_NONFATAL_REQ: s_d.rdata = {16'h0, s_q.nonfatal_req};
            `MEL_IDX_CTRL:         s_d.rdata = {27'h0, s_q.enable};
            `MEL_IDX_STATUS:       s_d.rdata = {27'h0, s_q.filled};
            default:               s_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q        <= '0;
         s_q.enable <= `MEL_CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o     = s_q.rdata;
   assign wb_ack_o     = s_q.ack;
   assign log_filled_o = s_q.filled;

endmodule : mel_log_bank

// ==== mel_regs.svh ====
/*
 * Register indices, field positions and reset values of the memory error log bank.
 * Assumes it is included by the package and by the design, with byte address = 4 * index.
 */
// What this block does
// - The first fatal request error stores bank in 14:12, rank in 10:8, buffer id in 7:0.
// - Each request and configuration log has a direction bit 11: 0 is read, 1 is write.
// - The first fatal memory error also stores column in 27:16 and row in 14:0 of a second log.
// - The first configuration access error stores byte enables, offset, function and id.
// - The first fatal northbound CRC error stores the whole 156-bit frame: data, ECC and CRC.
// - The frame fills five words in ascending order; the fifth holds 155:128 in 27:0.
// - The first correctable ECC error latches an 18-bit locator of the symbol pair in error.
// - Locator 7:0 are data pairs 1:0-15:14, 8 check 1:0, 16:9 data 17:16-31:30, 17 check 3:2.
// - The first non-fatal memory error stores bank, rank, direction and id in the fatal layout.
`ifndef MEL_REGS_SVH
`define MEL_REGS_SVH

// Register indices.
`define MEL_IDX_ECC_LOC      10'h07c
`define MEL_IDX_FATAL_REQ    10'h0be
`define MEL_IDX_FATAL_ADDR   10'h0c0
`define MEL_IDX_CFG_ERR      10'h0c4
`define MEL_IDX_CRC_A        10'h0c8
`define MEL_IDX_CRC_B        10'h0cc
`define MEL_IDX_CRC_C        10'h0d0
`define MEL_IDX_CRC_D        10'h0d4
`define MEL_IDX_CRC_E        10'h0d8
`define MEL_IDX_NONFATAL_REQ 10'h0e2
`define MEL_IDX_CTRL         10'h080
`define MEL_IDX_STATUS       10'h081

// Request log fields.
`define MEL_REQ_BANK_LSB     12
`define MEL_REQ_DIR_BIT      11
`define MEL_REQ_RANK_LSB     8
`define MEL_REQ_BUF_LSB      0
// Address log fields.
`define MEL_ADDR_COL_LSB     16
`define MEL_ADDR_ROW_LSB     0
// Configuration log fields.
`define MEL_CFG_BE_LSB       24
`define MEL_CFG_REG_LSB      16
`define MEL_CFG_DIR_BIT      11
`define MEL_CFG_FUNC_LSB     8
`define MEL_CFG_BUF_LSB      0
// Frame layout.
`define MEL_FRAME_W          156
`define MEL_FRAME_TOP_W      28
`define MEL_LOC_W            18

// Control: one capture enable per log class, bit order as the status word.
`define MEL_CTRL_RESET       5'h1f
`define MEL_LOG_CLASSES      5
`define MEL_LOG_RESET        32'h0

`endif

// ==== mel_pkg.sv ====
/*
 * Types of the memory error log bank.
 * Assumes the constant header is on the include path.
 */
`include "mel_regs.svh"

package mel_pkg;

   // One memory request error as reported by a channel.
   typedef struct packed {
      logic        valid;
      logic [2:0]  bank;
      logic [2:0]  rank;
      logic        dir;
      logic [7:0]  buf_id;
      logic [11:0] col;
      logic [14:0] row;
   } mel_mem_evt_t;

   // One DIMM configuration access error.
   typedef struct packed {
      logic       valid;
      logic [3:0] byte_lane_enables;
      logic [7:0] reg_offset;
      logic [2:0] func;
      logic       dir;
      logic [7:0] buf_id;
   } mel_cfg_evt_t;

   // One northbound frame that failed CRC.
   typedef struct packed {
      logic                     valid;
      logic [`MEL_FRAME_W-1:0]  frame;
   } mel_crc_evt_t;

   // One correctable ECC error, one flag per symbol pair in code word order.
   typedef struct packed {
      logic        valid;
      logic [15:0] data_pair;
      logic [1:0]  check_pair;
   } mel_ecc_evt_t;

   // Log class order, shared by the control and status words.
   typedef enum logic [2:0] {
      MEL_CLS_FATAL_MEM,
      MEL_CLS_NONFATAL_MEM,
      MEL_CLS_CFG,
      MEL_CLS_CRC,
      MEL_CLS_ECC
   } mel_cls_t;

   // Every flip-flop of the bank.
   typedef struct packed {
      logic [15:0]                  fatal_req;
      logic [31:0]                  fatal_addr;
      logic [31:0]                  cfg_log;
      logic [`MEL_FRAME_W-1:0]      crc_frame;
      logic [`MEL_LOC_W-1:0]        ecc_loc;
      logic [15:0]                  nonfatal_req;
      logic [`MEL_LOG_CLASSES-1:0]  filled;
      logic [`MEL_LOG_CLASSES-1:0]  enable;
      logic                         ack;
      logic [31:0]                  rdata;
   } mel_state_t;

endpackage : mel_pkg

// ==== mel_log_bank_sva.sv ====
/* Port checker of the log bank. Bound to every mel_log_bank instance. */
`timescale 1ns/1ps
module mel_log_bank_sva
   import mel_pkg::*;
(
   // Bus and status
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic [11:0]  wb_adr_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic [4:0]   log_filled_o,
   // Error reports
   input wire mel_crc_evt_t crc_err_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [9:0] ix;
   assign ix = wb_adr_i[11:2];
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data leak");
   fill_keep_a: assert property (
      (log_filled_o & $past(log_filled_o)) == $past(log_filled_o)) else $error("flag lost");
   crc_cause_a: assert property (
      $rose(log_filled_o[3]) |-> $past(crc_err_i.valid)) else $error("crc fill uncaused");
   ecc_reserved_a: assert property (
      wb_ack_o && ix == 10'h07c |-> wb_dat_o[31:18] == 14'h0) else $error("ecc rsv");
   req_reserved_a: assert property (
      wb_ack_o && (ix == 10'h0be || ix == 10'h0e2) |-> wb_dat_o[31:15] == 17'h0)
      else $error("req rsv");
   cfg_reserved_a: assert property (
      wb_ack_o && ix == 10'h0c4 |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:12] == 4'h0)
      else $error("cfg rsv");
   crc_top_a: assert property (
      wb_ack_o && ix == 10'h0d8 |-> wb_dat_o[31:28] == 4'h0) else $error("crc rsv");
endmodule : mel_log_bank_sva

bind mel_log_bank mel_log_bank_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .log_filled_o(log_filled_o), .crc_err_i(crc_err_i));

// ==== mel_chan_model.sv ====
/* Memory channel model. The bench fires each report class through fire_i. */
`timescale 1ns/1ps
module mel_chan_model
   import mel_pkg::*;
(
   // Commands
   input  wire logic [4:0]  fire_i,
   input  wire logic [31:0] pat_i,
   // Error reports
   output mel_mem_evt_t     fatal_o,
   output mel_mem_evt_t     nonfatal_o,
   output mel_cfg_evt_t     cfg_o,
   output mel_crc_evt_t     crc_o,
   output mel_ecc_evt_t     ecc_o
);
   logic [63:0] w;
   // Idle fields carry the inverse pattern, so a late sample cannot pass.
   assign w = {64{|fire_i}} ~^ {pat_i, pat_i ^ 32'h5a5a5a5a};
   assign fatal_o = {fire_i[0], w[41:0]};
   assign nonfatal_o = {fire_i[1], w[63:22]};
   assign cfg_o = {fire_i[2], w[23:0]};
   assign crc_o = {fire_i[3], w[59:0], w, w[31:0]};
   assign ecc_o = {fire_i[4], w[17:0]};
endmodule : mel_chan_model

// ==== test_memory_error_log_bank.sv ====
/* Bench of the log bank. Needs the channel model and the checker. */
`timescale 1ns/1ps
module test_memory_error_log_bank
   import mel_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [11:0] adr = 12'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, pat = 32'h0, rdat, rd;
   logic [4:0] fire = 5'h0, filled;
   mel_mem_evt_t fm, nm;
   mel_cfg_evt_t ce;
   mel_crc_evt_t cr;
   mel_ecc_evt_t ec;
   int mismatches = 0, checks = 0, ticks = 0;
   mel_log_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fatal_mem_i(fm), .nonfatal_mem_i(nm), .cfg_err_i(ce),
      .crc_err_i(cr), .ecc_err_i(ec), .log_filled_o(filled));
   mel_chan_model i_chan (.fire_i(fire), .pat_i(pat), .fatal_o(fm), .nonfatal_o(nm),
      .cfg_o(ce), .crc_o(cr), .ecc_o(ec));
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ticks <= ticks + 1;
      if (ticks == 2000) begin
         mismatches++;
         $display("[FAIL] %0t timeout", $time);
         complete_run();
      end
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask : bus
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      checks++;
      if (rd !== e) begin
         mismatches++;
         $display("[FAIL] %0t at %h read %h want %h", $time, a, rd, e);
      end
   endtask : rchk
   task automatic fchk(input logic [4:0] e);
      checks++;
      if (filled !== e) begin
         mismatches++;
         $display("[FAIL] %0t filled %h want %h", $time, filled, e);
      end
   endtask : fchk
   task automatic fire_all(input logic [31:0] s);
      pat <= s;
      fire <= 5'h1f;
      @(posedge clk_i);
      fire <= 5'h0;
      @(posedge clk_i);
   endtask : fire_all
   task automatic chk_logs(input logic [31:0] s, input logic [4:0] m);
      logic [63:0]  x;
      logic [159:0] f;
      x = {s, s ^ 32'h5a5a5a5a};
      f = {x, x, x[31:0]} & {160{m[3]}};
      fchk(m);
      rchk(12'h2f8, {17'h0, x[41:39], x[35], x[38:36], x[34:27]} & {32{m[0]}});
      rchk(12'h300, {4'h0, x[26:15], 1'b0, x[14:0]} & {32{m[0]}});
      rchk(12'h310, {4'h0, x[23:20], x[19:12], 4'h0, x[8], x[11:9], x[7:0]} & {32{m[2]}});
      for (int i = 0; i < 4; i++) rchk(12'h320 + 12'(16 * i), f[32*i +: 32]);
      rchk(12'h360, {4'h0, f[155:128]});
      rchk(12'h1f0, {14'h0, x[1], x[17:10], x[0], x[9:2]} & {32{m[4]}});
      rchk(12'h388, {17'h0, x[63:61], x[57], x[60:58], x[56:49]} & {32{m[1]}});
   endtask : chk_logs
   task automatic t_reset;
      chk_logs(32'h0, 5'h00);
      rchk(12'h204, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_capture;
      fire_all(32'h12345678);
      chk_logs(32'h12345678, 5'h1f);
      rchk(12'h204, 32'h1f);
      $display("test capture done");
   endtask : t_capture
   task automatic t_keep;
      fire_all(32'h3c96e10f);
      bus(1'b1, 12'h1f0, 32'hffffffff);
      bus(1'b1, 12'h360, 32'hffffffff);
      chk_logs(32'h12345678, 5'h1f);
      rchk(12'h3fc, 32'h0);
      $display("test keep done");
   endtask : t_keep
   task automatic t_enable;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_logs(32'h0, 5'h00);
      rchk(12'h200, 32'h1f);
      bus(1'b1, 12'h200, 32'h15);
      rchk(12'h200, 32'h15);
      fire_all(32'h0f0f1234);
      chk_logs(32'h0f0f1234, 5'h15);
      $display("test enable done");
   endtask : t_enable
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_capture();
      t_keep();
      t_enable();
      complete_run();
   end
endmodule : test_memory_error_log_bank
